// File: core/fsh_pkg.sv
// Shared constants of the flash status polling controller
package fsh_pkg;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 4;

  // Status bit positions in the byte returned by the flash during an operation
  localparam int BIT_POLL   = 7;
  localparam int BIT_TOG1   = 6;
  localparam int BIT_TMO    = 5;
  localparam int BIT_ERTIME = 3;
  localparam int BIT_TOG2   = 2;

  // Single-cycle reset command data
  localparam logic [DATA_W-1:0] CMD_RESET = 8'hF0;

  // Strobe timing in ns and the derived clock counts at 100 MHz
  localparam int CLK_NS       = 10;
  localparam int RD_STROBE_NS = 70;
  localparam int WR_STROBE_NS = 35;
  localparam int GAP_NS       = 20;
  localparam logic [CNT_W-1:0] RD_CYC  = CNT_W'((RD_STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] WR_CYC  = CNT_W'((WR_STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] GAP_CYC = CNT_W'((GAP_NS + CLK_NS - 1) / CLK_NS);
endpackage : fsh_pkg

// File: core/fsh_bus_cycle.sv
// One read or write strobe cycle on the flash pins, followed by a release gap
`timescale 1ns/1ps
module fsh_bus_cycle (
  input  wire logic                        clk,
  input  wire logic                        nrst,
  input  wire logic                        req,
  input  wire logic                        wr,
  input  wire logic [fsh_pkg::DATA_W-1:0]  wdata,
  output logic                             ready,
  output logic                             ack,
  output logic      [fsh_pkg::DATA_W-1:0]  rdata,
  output logic                             ce_n,
  output logic                             oe_n,
  output logic                             we_n,
  output logic      [fsh_pkg::DATA_W-1:0]  dq_out,
  output logic                             dq_oe_n,
  input  wire logic [fsh_pkg::DATA_W-1:0]  dq_in
);
  typedef enum logic [2:0] {
    CY_IDLE   = 3'b001,
    CY_STROBE = 3'b010,
    CY_GAP    = 3'b100
  } fsh_cy_type;

  fsh_cy_type                   state, next_state;
  logic [fsh_pkg::CNT_W-1:0]    cnt, next_cnt;
  logic                         wr_q, next_wr_q;
  logic                         next_ack;
  logic [fsh_pkg::DATA_W-1:0]   next_rdata, next_dq_out;
  logic                         next_ce_n, next_oe_n, next_we_n, next_dq_oe_n;

  assign ready = (state == CY_IDLE);

  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_wr_q    = wr_q;
    next_ack     = 1'b0;
    next_rdata   = rdata;
    next_dq_out  = dq_out;
    next_ce_n    = ce_n;
    next_oe_n    = oe_n;
    next_we_n    = we_n;
    next_dq_oe_n = dq_oe_n;
    unique case (state)
      CY_IDLE: begin
        if (req) begin
          next_state   = CY_STROBE;
          next_cnt     = wr ? fsh_pkg::WR_CYC - 4'h1 : fsh_pkg::RD_CYC - 4'h1;
          next_wr_q    = wr;
          next_ce_n    = 1'b0;
          next_oe_n    = wr;
          next_we_n    = ~wr;
          next_dq_out  = wdata;
          next_dq_oe_n = ~wr;
        end
      end
      CY_STROBE: begin
        if (cnt == 4'h0) begin
          // Release every strobe so each read is a separate sample
          next_state   = CY_GAP;
          next_cnt     = fsh_pkg::GAP_CYC - 4'h1;
          next_ack     = 1'b1;
          next_ce_n    = 1'b1;
          next_oe_n    = 1'b1;
          next_we_n    = 1'b1;
          next_dq_oe_n = 1'b1;
          if (!wr_q) begin
            next_rdata = dq_in;
          end
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      CY_GAP: begin
        if (cnt == 4'h0) begin
          next_state = CY_IDLE;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      default: begin
        next_state = CY_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state   <= CY_IDLE;
      cnt     <= 4'h0;
      wr_q    <= 1'b0;
      ack     <= 1'b0;
      rdata   <= 8'h00;
      dq_out  <= 8'h00;
      ce_n    <= 1'b1;
      oe_n    <= 1'b1;
      we_n    <= 1'b1;
      dq_oe_n <= 1'b1;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      wr_q    <= next_wr_q;
      ack     <= next_ack;
      rdata   <= next_rdata;
      dq_out  <= next_dq_out;
      ce_n    <= next_ce_n;
      oe_n    <= next_oe_n;
      we_n    <= next_we_n;
      dq_oe_n <= next_dq_oe_n;
    end
  end

  property p_read_strobe_len;
    @(posedge clk) disable iff (!nrst) $fell(oe_n) |-> (!oe_n && !ce_n)[*7] ##1 oe_n;
  endproperty
  a_read_strobe_len: assert property (p_read_strobe_len) else $error("read strobe length wrong");

  property p_release_gap;
    @(posedge clk) disable iff (!nrst) $rose(ce_n) |-> (ce_n && oe_n && we_n)[*3];
  endproperty
  a_release_gap: assert property (p_release_gap) else $error("strobes not released between cycles");

  property p_no_overlap;
    @(posedge clk) disable iff (!nrst) !(!oe_n && !we_n) && (!dq_oe_n == !we_n);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("read and write strobes overlap");
endmodule : fsh_bus_cycle

// File: core/fsh_poll_ctrl.sv
// Host controller that polls a parallel flash for write operation status
`timescale 1ns/1ps
module fsh_poll_ctrl (
  input  wire logic                        clk,
  input  wire logic                        nrst,
  input  wire logic                        start,
  input  wire logic                        toggle_mode,
  input  wire logic                        use_toggle_two,
  input  wire logic [fsh_pkg::ADDR_W-1:0]  poll_addr,
  input  wire logic [fsh_pkg::DATA_W-1:0]  expect_data,
  input  wire logic                        abort,
  output logic                             busy,
  output logic                             done,
  output logic                             pass,
  output logic                             fail,
  output logic      [fsh_pkg::DATA_W-1:0]  result_data,
  output logic      [fsh_pkg::DATA_W-1:0]  status_byte,
  output logic                             device_ready,
  output logic      [fsh_pkg::ADDR_W-1:0]  flash_addr,
  output logic                             flash_ce_n,
  output logic                             flash_oe_n,
  output logic                             flash_we_n,
  output logic      [fsh_pkg::DATA_W-1:0]  flash_dq_out,
  output logic                             flash_dq_oe_n,
  input  wire logic [fsh_pkg::DATA_W-1:0]  flash_dq_in,
  input  wire logic                        ready_busy_out
);
  typedef enum logic [6:0] {
    S_IDLE    = 7'b0000001,
    S_FIRST   = 7'b0000010,
    S_SECOND  = 7'b0000100,
    S_RECHECK = 7'b0001000,
    S_FINAL   = 7'b0010000,
    S_RSTCMD  = 7'b0100000,
    S_DONE    = 7'b1000000
  } fsh_st_type;

  fsh_st_type                  state, next_state;
  logic [fsh_pkg::DATA_W-1:0]  prev, next_prev, exp_q, next_exp_q;
  logic [fsh_pkg::DATA_W-1:0]  next_result_data, next_status_byte;
  logic [fsh_pkg::ADDR_W-1:0]  next_flash_addr;
  logic                        mode_q, next_mode_q, two_q, next_two_q;
  logic                        pending, next_pending;
  logic                        next_pass, next_fail, next_device_ready;
  logic [1:0]                  rd_cnt, next_rd_cnt;
  logic                        saw_tmo, next_saw_tmo;
  logic                        cyc_req, cyc_wr, cyc_ready, cyc_ack;
  logic [fsh_pkg::DATA_W-1:0]  cyc_rdata;
  logic                        polling, tog_moved, poll_hit, still_busy;

  fsh_bus_cycle u_cycle (
    .clk     (clk),
    .nrst    (nrst),
    .req     (cyc_req),
    .wr      (cyc_wr),
    .wdata   (fsh_pkg::CMD_RESET),
    .ready   (cyc_ready),
    .ack     (cyc_ack),
    .rdata   (cyc_rdata),
    .ce_n    (flash_ce_n),
    .oe_n    (flash_oe_n),
    .we_n    (flash_we_n),
    .dq_out  (flash_dq_out),
    .dq_oe_n (flash_dq_oe_n),
    .dq_in   (flash_dq_in)
  );

  assign polling = (state == S_FIRST) || (state == S_SECOND) || (state == S_RECHECK)
                || (state == S_FINAL) || (state == S_RSTCMD);
  assign cyc_req = polling && cyc_ready && !pending && !abort;
  assign cyc_wr  = (state == S_RSTCMD);
  assign busy    = (state != S_IDLE);
  assign done    = (state == S_DONE);

  // Toggle bit 6, or toggle bit 2 when use_toggle_two is set, moving between two reads means the operation still runs
  assign tog_moved = (cyc_rdata[fsh_pkg::BIT_TOG1] ^ prev[fsh_pkg::BIT_TOG1])
                   | (two_q & (cyc_rdata[fsh_pkg::BIT_TOG2] ^ prev[fsh_pkg::BIT_TOG2]));
  assign poll_hit   = (cyc_rdata[fsh_pkg::BIT_POLL] == exp_q[fsh_pkg::BIT_POLL]);
  assign still_busy = mode_q ? tog_moved : !poll_hit;

  always_comb begin
    next_state        = state;
    next_prev         = prev;
    next_exp_q        = exp_q;
    next_mode_q       = mode_q;
    next_two_q        = two_q;
    next_flash_addr   = flash_addr;
    next_pending      = pending;
    next_pass         = pass;
    next_fail         = fail;
    next_result_data  = result_data;
    next_status_byte  = status_byte;
    next_rd_cnt       = rd_cnt;
    next_saw_tmo      = saw_tmo;
    next_device_ready = ready_busy_out;
    if (cyc_req) begin
      next_pending = 1'b1;
    end
    if (cyc_ack) begin
      next_pending = 1'b0;
      if (state != S_RSTCMD) begin
        next_status_byte = cyc_rdata;
        next_rd_cnt      = (rd_cnt == 2'h3) ? rd_cnt : rd_cnt + 2'h1;
        if (cyc_rdata[fsh_pkg::BIT_TMO]) begin
          next_saw_tmo = 1'b1;
        end
      end
    end
    unique case (state)
      S_IDLE: begin
        if (start) begin
          // Every new check begins with the first of two reads
          next_state      = S_FIRST;
          next_flash_addr = poll_addr;
          next_exp_q      = expect_data;
          next_mode_q     = toggle_mode;
          next_two_q      = use_toggle_two;
          next_pass       = 1'b0;
          next_fail       = 1'b0;
          next_rd_cnt     = 2'h0;
          next_saw_tmo    = 1'b0;
        end
      end
      S_FIRST, S_SECOND, S_RECHECK, S_FINAL, S_RSTCMD: begin
        if (abort && cyc_ready && !pending) begin
          next_state = S_IDLE;
        end else if (cyc_ack) begin
          next_prev = cyc_rdata;
          if (state == S_FIRST) begin
            next_state = S_SECOND;
          end else if (state == S_SECOND) begin
            if (!still_busy) begin
              next_state = S_FINAL;
            end else if (cyc_rdata[fsh_pkg::BIT_TMO]) begin
              next_state = S_RECHECK;
            end
          end else if (state == S_RECHECK) begin
            next_state = still_busy ? S_RSTCMD : S_FINAL;
          end else if (state == S_FINAL) begin
            next_result_data = cyc_rdata;
            next_pass        = 1'b1;
            next_state       = S_DONE;
          end else begin
            next_fail  = 1'b1;
            next_state = S_DONE;
          end
        end
      end
      S_DONE: begin
        next_state = S_IDLE;
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state        <= S_IDLE;
      prev         <= 8'h00;
      exp_q        <= 8'h00;
      mode_q       <= 1'b0;
      two_q        <= 1'b0;
      flash_addr   <= 21'h000000;
      pending      <= 1'b0;
      pass         <= 1'b0;
      fail         <= 1'b0;
      result_data  <= 8'h00;
      status_byte  <= 8'h00;
      rd_cnt       <= 2'h0;
      saw_tmo      <= 1'b0;
      device_ready <= 1'b0;
    end else begin
      state        <= next_state;
      prev         <= next_prev;
      exp_q        <= next_exp_q;
      mode_q       <= next_mode_q;
      two_q        <= next_two_q;
      flash_addr   <= next_flash_addr;
      pending      <= next_pending;
      pass         <= next_pass;
      fail         <= next_fail;
      result_data  <= next_result_data;
      status_byte  <= next_status_byte;
      rd_cnt       <= next_rd_cnt;
      saw_tmo      <= next_saw_tmo;
      device_ready <= next_device_ready;
    end
  end

  property p_addr_held;
    @(posedge clk) disable iff (!nrst) (busy && $past(busy)) |-> $stable(flash_addr);
  endproperty
  a_addr_held: assert property (p_addr_held) else $error("address moved during polling");

  property p_two_reads_first;
    @(posedge clk) disable iff (!nrst) (state == S_FINAL && cyc_req) |-> rd_cnt >= 2'h2;
  endproperty
  a_two_reads_first: assert property (p_two_reads_first) else $error("final read too early");

  property p_reset_only_on_timeout;
    @(posedge clk) disable iff (!nrst) (state == S_RSTCMD) |-> saw_tmo && rd_cnt >= 2'h3;
  endproperty
  a_reset_only_on_timeout: assert property (p_reset_only_on_timeout) else $error("reset without timeout");

  property p_reset_data;
    @(posedge clk) disable iff (!nrst) !flash_we_n |-> flash_dq_out == fsh_pkg::CMD_RESET;
  endproperty
  a_reset_data: assert property (p_reset_data) else $error("reset command data wrong");

  property p_fail_after_reset;
    @(posedge clk) disable iff (!nrst) $rose(fail) |-> $past(state) == S_RSTCMD ##1 state == S_IDLE;
  endproperty
  a_fail_after_reset: assert property (p_fail_after_reset) else $error("failure without reset");

  property p_restart;
    @(posedge clk) disable iff (!nrst) (state == S_IDLE && start) |=> state == S_FIRST && rd_cnt == 2'h0;
  endproperty
  a_restart: assert property (p_restart) else $error("check did not restart from first read");

  property p_read_per_sample;
    @(posedge clk) disable iff (!nrst) cyc_ack |-> ##[1:4] !cyc_ack ##0 flash_oe_n;
  endproperty
  a_read_per_sample: assert property (p_read_per_sample) else $error("reads not separated");

  c_pass: cover property (@(posedge clk) disable iff (!nrst) $rose(pass));
  c_fail: cover property (@(posedge clk) disable iff (!nrst) $rose(fail));
  c_recheck_ok: cover property (@(posedge clk) disable iff (!nrst)
    state == S_RECHECK ##[1:40] state == S_FINAL);
  c_abort: cover property (@(posedge clk) disable iff (!nrst) state == S_SECOND ##1 state == S_IDLE);
endmodule : fsh_poll_ctrl

// File: tb/fsh_flash_model.sv
// Behavioural byte-wide flash that answers status reads during embedded operations
`timescale 1ns/1ps
module fsh_flash_model (
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [7:0]  dq_out,
  input  wire logic        dq_oe_n,
  output logic      [7:0]  dq_in,
  output logic             rb,
  input  wire logic        arm,
  input  wire logic [2:0]  op,
  input  wire logic [7:0]  nreads,
  input  wire logic [7:0]  pdata,
  input  wire logic [7:0]  odata,
  input  wire logic        late,
  output logic      [7:0]  resets
);
  // Modes: 0 array, 1 program, 2 erase, 3 failing program, 4 protected program,
  // 5 erase suspended, 6 erase with every selected sector protected
  logic [2:0] mode = 3'h0;
  logic [7:0] left = 8'h00;
  logic [7:0] mem  = 8'h00;
  logic [7:0] last = 8'h00;
  logic [7:0] stat;
  logic [7:0] cur;
  logic       t1   = 1'b0;
  logic       t2   = 1'b0;
  logic       rst_seen = 1'b0;
  logic       rd;
  logic       wr;
  logic       active;
  logic       ers;
  initial resets = 8'h00;
  assign rd = !ce_n && !oe_n;
  assign wr = !ce_n && !we_n;
  assign ers = (mode == 3'h2) || (mode == 3'h5) || (mode == 3'h6);
  assign active = (left != 8'h00) || (mode == 3'h3) || (mode == 3'h5);
  assign stat = {ers ? (mode == 3'h5) : ~pdata[7], t1,
                 (mode == 3'h3 && left == 8'h00) || (late && left == 8'h01),
                 1'b0, ers, t2, 2'h0};
  assign cur = active ? stat : mem;
  // Released bus shows the inverse of the last byte, never a stale copy
  assign dq_in = rd ? cur : ~last;
  assign rb = !(active && mode != 3'h5);
  // Status mode starts at the rising edge of arm, driven by the bench
  always @(posedge arm) begin
    mode = op;
    left = nreads;
    mem = odata;
    t1 = 1'b0;
    t2 = 1'b0;
  end
  // Each completed read cycle is one toggle sample
  always @(negedge rd) begin
    last = cur;
    if (active) begin
      if (mode != 3'h5) t1 = ~t1;
      if (ers) t2 = ~t2;
      if (left != 8'h00) begin
        left = left - 8'h01;
        // Protected sectors keep their old contents
        if (left == 8'h00 && mode == 3'h1) mem = pdata;
        if (left == 8'h00 && mode == 3'h2) mem = 8'hFF;
      end
    end
  end
  always @(wr or dq_out or dq_oe_n) begin
    if (wr && !dq_oe_n && dq_out == 8'hF0) rst_seen = 1'b1;
  end
  // Reset command is taken when the write strobe ends
  always @(negedge wr) begin
    if (rst_seen) begin
      mode = 3'h0;
      left = 8'h00;
      resets = resets + 8'h01;
      rst_seen = 1'b0;
    end
  end
endmodule : fsh_flash_model

// File: tb/tb.sv
// Self-checking bench for the flash status polling controller
`timescale 1ns/1ps
module tb;
  typedef struct packed {logic p; logic f; logic [7:0] d;} fsh_exp_type;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic start = 1'b0, toggle_mode = 1'b0, use_toggle_two = 1'b0, abort = 1'b0;
  logic [20:0] poll_addr = 21'h000000, cur_addr = 21'h000000;
  logic [7:0] expect_data = 8'h00, result_data, status_byte, flash_dq_out, flash_dq_in;
  logic busy, done, pass, fail, device_ready, flash_ce_n, flash_oe_n, flash_we_n;
  logic flash_dq_oe_n, rb;
  logic [20:0] flash_addr;
  logic arm = 1'b0, m_late = 1'b0;
  logic [2:0] m_op = 3'h0;
  logic [7:0] m_n = 8'h00, m_pd = 8'h00, m_od = 8'h00, resets, rnd;
  integer seed;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  fsh_exp_type exp_q[$];
  fsh_exp_type mon_e;

  always #5 clk = ~clk;

  fsh_poll_ctrl u_dut (.clk(clk), .nrst(nrst), .start(start), .toggle_mode(toggle_mode),
    .use_toggle_two(use_toggle_two), .poll_addr(poll_addr), .expect_data(expect_data),
    .abort(abort), .busy(busy), .done(done), .pass(pass), .fail(fail),
    .result_data(result_data), .status_byte(status_byte), .device_ready(device_ready),
    .flash_addr(flash_addr), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n), .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n),
    .flash_dq_in(flash_dq_in), .ready_busy_out(rb));

  fsh_flash_model u_flash (.ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n),
    .dq_out(flash_dq_out), .dq_oe_n(flash_dq_oe_n), .dq_in(flash_dq_in), .rb(rb),
    .arm(arm), .op(m_op), .nreads(m_n), .pdata(m_pd), .odata(m_od), .late(m_late),
    .resets(resets));

  task automatic stop_test();
    $display("Summary: %0d compares, %0d errors", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  task automatic check_bit(input string nm, input logic ex, input logic got);
    compares++;
    if (got !== ex) begin
      bad_count++;
      $display("Error %s expected %b seen %b", nm, ex, got);
    end
  endtask : check_bit

  task automatic check_byte(input string nm, input logic [7:0] ex, input logic [7:0] got);
    compares++;
    if (got !== ex) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : check_byte

  task automatic check_addr(input string nm, input logic [20:0] ex, input logic [20:0] got);
    compares++;
    if (got !== ex) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : check_addr

  task automatic wait_idle();
    int k;
    for (k = 0; k < 3000 && busy !== 1'b0; k++) @(negedge clk);
    if (busy !== 1'b0) check_bit("idle_wait", 1'b0, busy);
  endtask : wait_idle

  // Arm the flash with one operation, start a check and note the expected outcome
  task automatic go(input logic [2:0] o, input logic [7:0] n, input logic tm,
                    input logic t2, input logic lt, input logic [7:0] pd,
                    input logic [7:0] od, input logic ep, input logic wt);
    fsh_exp_type e;
    logic eb;
    logic et;
    e.p = ep;
    e.f = !ep;
    e.d = (o == 3'h1) ? pd : (o == 3'h2) ? 8'hFF : od;
    eb = (o == 3'h5) || (o != 3'h2 && o != 3'h6 && !pd[7]);
    et = (o == 3'h2) || (o == 3'h5) || (o == 3'h6);
    @(posedge clk);
    m_op <= o;
    m_n <= n;
    m_pd <= pd;
    m_od <= od;
    m_late <= lt;
    @(posedge clk);
    arm <= 1'b1;
    @(posedge clk);
    arm <= 1'b0;
    start <= 1'b1;
    toggle_mode <= tm;
    use_toggle_two <= t2;
    cur_addr = 21'($random(seed));
    poll_addr <= cur_addr;
    expect_data <= (o == 3'h2 || o == 3'h6) ? 8'hFF : pd;
    if (wt) exp_q.push_back(e);
    @(posedge clk);
    start <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check_bit("device_ready", o == 3'h5, device_ready);
    repeat (5) @(posedge clk);
    @(negedge clk);
    check_bit("status_bit7", eb, status_byte[fsh_pkg::BIT_POLL]);
    check_bit("erase_timer_flag", et, status_byte[fsh_pkg::BIT_ERTIME]);
    if (wt) begin
      wait_idle();
      check_bit("device_ready", 1'b1, device_ready);
    end
  endtask : go

  // Result monitor and address watch
  always @(negedge clk) begin
    if (flash_oe_n === 1'b0) check_addr("flash_addr", cur_addr, flash_addr);
    if (done === 1'b1) begin
      if (exp_q.size() == 0) begin
        check_bit("unexpected_done", 1'b0, 1'b1);
      end else begin
        mon_e = exp_q.pop_front();
        check_bit("pass", mon_e.p, pass);
        check_bit("fail", mon_e.f, fail);
        if (mon_e.p) check_byte("result_data", mon_e.d, result_data);
      end
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      stop_test();
    end
  end

  initial begin
    seed = 32'hDF9AD71F;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rnd = 8'($random(seed));
    go(3'h1, 8'h05, 1'b0, 1'b0, 1'b0, 8'h3C, 8'h00, 1'b1, 1'b1);
    go(3'h1, 8'h06, 1'b1, 1'b0, 1'b0, rnd, 8'h00, 1'b1, 1'b1);
    go(3'h2, 8'h06, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 1'b1, 1'b1);
    go(3'h2, 8'h07, 1'b1, 1'b1, 1'b0, 8'h00, 8'h00, 1'b1, 1'b1);
    go(3'h1, 8'h03, 1'b1, 1'b0, 1'b1, 8'h15, 8'h00, 1'b1, 1'b1);
    go(3'h4, 8'h04, 1'b1, 1'b0, 1'b0, 8'h00, 8'h5A, 1'b1, 1'b1);
    go(3'h6, 8'h05, 1'b1, 1'b1, 1'b0, 8'h00, 8'h33, 1'b1, 1'b1);
    go(3'h3, 8'h04, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 1'b1);
    check_byte("reset_writes", 8'h01, resets);
    check_bit("timeout_flag", 1'b1, status_byte[fsh_pkg::BIT_TMO]);
    go(3'h3, 8'h03, 1'b0, 1'b0, 1'b0, 8'h80, 8'h00, 1'b0, 1'b1);
    check_byte("reset_writes", 8'h02, resets);
    go(3'h5, 8'h00, 1'b1, 1'b1, 1'b0, 8'h00, 8'h00, 1'b1, 1'b0);
    repeat (40) @(negedge clk);
    check_bit("busy", 1'b1, busy);
    @(posedge clk);
    abort <= 1'b1;
    wait_idle();
    check_bit("busy", 1'b0, busy);
    @(posedge clk);
    abort <= 1'b0;
    go(3'h1, 8'h02, 1'b1, 1'b0, 1'b0, 8'hC3, 8'h00, 1'b1, 1'b1);
    repeat (5) @(posedge clk);
    check_byte("pending_results", 8'h00, 8'(exp_q.size()));
    stop_test();
  end
endmodule : tb
